//--- src/dtcc_pkg.sv
package dtcc_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned DTCC_NCH = 16;
  localparam int unsigned DTCC_AW  = 6;
  localparam int unsigned DTCC_DW  = 16;
  localparam int unsigned DTCC_PW  = 11;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [5:0] DTCC_ADDR_TMR0   = 6'h00;
  localparam logic [5:0] DTCC_ADDR_TMR1   = 6'h01;
  localparam logic [5:0] DTCC_ADDR_REL0   = 6'h02;
  localparam logic [5:0] DTCC_ADDR_REL1   = 6'h03;
  localparam logic [5:0] DTCC_ADDR_TCTL   = 6'h04;
  localparam logic [5:0] DTCC_ADDR_OUT    = 6'h05;
  localparam logic [5:0] DTCC_ADDR_PEN    = 6'h06;
  localparam logic [5:0] DTCC_ADDR_OCTL   = 6'h07;
  localparam logic [5:0] DTCC_ADDR_SWTRIG = 6'h08;
  localparam logic [5:0] DTCC_ADDR_CCV    = 6'h10;
  localparam logic [5:0] DTCC_ADDR_MODE   = 6'h20;

  // ---------------------------------------------------------------
  // Timer control fields, one byte per timer
  // ---------------------------------------------------------------
  localparam int unsigned DTCC_TCTL_STRIDE = 8;
  localparam int unsigned DTCC_TCTL_PRE    = 0;
  localparam int unsigned DTCC_TCTL_SRC    = 3;
  localparam int unsigned DTCC_TCTL_RUN    = 6;
  localparam logic [1:0]  DTCC_SRC_PRESC   = 2'h0;
  localparam logic [1:0]  DTCC_SRC_AUX     = 2'h1;
  localparam logic [1:0]  DTCC_SRC_EXT     = 2'h2;

  // ---------------------------------------------------------------
  // Channel mode fields
  // ---------------------------------------------------------------
  localparam int unsigned DTCC_MODE_OP   = 0;
  localparam int unsigned DTCC_MODE_TSEL = 2;
  localparam int unsigned DTCC_MODE_EDGE = 3;
  localparam int unsigned DTCC_MODE_ACT  = 5;
  localparam logic [1:0]  DTCC_OP_CAP    = 2'h1;
  localparam logic [1:0]  DTCC_OP_CMP    = 2'h2;
  localparam logic [1:0]  DTCC_ACT_SET   = 2'h1;
  localparam logic [1:0]  DTCC_ACT_CLR   = 2'h2;
  localparam logic [1:0]  DTCC_ACT_TGL   = 2'h3;

  // ---------------------------------------------------------------
  // Output control fields and stagger
  // ---------------------------------------------------------------
  localparam int unsigned DTCC_OCTL_STAG  = 0;
  localparam int unsigned DTCC_OCTL_DBL   = 8;
  localparam int unsigned DTCC_STAG_STEPS = 8;
  localparam int unsigned DTCC_STAG_SHIFT = 3;

  // ---------------------------------------------------------------
  // Reset value and timer maximum
  // ---------------------------------------------------------------
  localparam logic [15:0] DTCC_RST_WORD = 16'h0000;
  localparam logic [15:0] DTCC_TMR_MAX  = 16'hFFFF;

endpackage

//--- src/dtcc_unit.sv
// Behaviour
// - Sixteen independent channels run timing sequences once configured.
// - Two 16-bit timers, each with its own reload register.
// - Sixteen 16-bit channel registers, each usable for capture or compare.
// - Timer clock: prescaled module clock or auxiliary timer overflow event.
// - First timer can count edges on an external input.
// - Each channel picks capture or compare and one of the two timers.
// - One pin per channel: capture input or compare output.
// - Capture edge stores the assigned timer value into the channel register.
// - Each capture event pulses that channel's interrupt request.
// - Compare match on timer increment may switch the channel output.
// - Each compare match pulses that channel's interrupt request.
// - Double-register mode: two channel registers control one output.
// - Compare outputs collect in an output register, optionally driving pins.
// - Software selects whether outputs reach the pins.
// - Staggered mode switches outputs over 8 steps; timer ticks every 8 clocks.
// - Non-staggered mode switches all pending outputs at once; 1-clock resolution.
// - Software can trigger each channel's interrupt request.
// - Timers only count upward.
// - Timer write beats a same-cycle increment or reload.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module dtcc_unit
  import dtcc_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                arst_n_in,
  // Register port
  input  wire logic [DTCC_AW-1:0]  reg_addr_in,
  input  wire logic [DTCC_DW-1:0]  reg_wdata_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  output logic      [DTCC_DW-1:0]  reg_rdata_out,
  // Timer count sources
  input  wire logic                aux_ovf_in,
  input  wire logic                ext_count_in,
  // Channel pins
  input  wire logic [DTCC_NCH-1:0] cc_pin_in,
  output logic      [DTCC_NCH-1:0] cc_pin_out,
  output logic      [DTCC_NCH-1:0] cc_pin_oe_n_out,
  // Events
  output logic      [DTCC_NCH-1:0] irq_out,
  output logic      [DTCC_NCH-1:0] out_reg_out,
  output logic      [1:0]          timer_ovf_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0][15:0]          tmr;
    logic [1:0][15:0]          rel;
    logic [15:0]               tctl;
    logic [DTCC_NCH-1:0]       outr;
    logic [DTCC_NCH-1:0]       pen;
    logic [15:0]               octl;
    logic [DTCC_NCH-1:0][15:0] ccv;
    logic [DTCC_NCH-1:0][7:0]  mode;
    logic [DTCC_NCH-1:0]       pin_prev;
    logic                      ext_prev;
    logic [DTCC_PW-1:0]        pre;
    logic [DTCC_NCH-1:0]       pend;
    logic [DTCC_NCH-1:0]       pend_val;
    logic [DTCC_NCH-1:0]       irq;
    logic [15:0]               rdata;
    logic [1:0]                ovf;
  } dtcc_state_s;

  dtcc_state_s q;
  dtcc_state_s next_q;

  logic                stag;
  logic [DTCC_PW-1:0]  pre_mask;
  logic                tick_pre;
  logic                ext_edge;
  logic [1:0]          tick;
  logic [1:0]          tmr_wr;
  logic [1:0]          inc;
  logic [1:0][15:0]    tmr_nx;
  logic [DTCC_NCH-1:0] match;
  logic [DTCC_NCH-1:0] cap_ev;
  logic [DTCC_NCH-1:0] out_req;
  logic [DTCC_NCH-1:0] out_val;
  logic [DTCC_NCH-1:0] is_cmp;

  // ---------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------
  assign stag     = q.octl[DTCC_OCTL_STAG];
  assign ext_edge = ext_count_in & ~q.ext_prev;

  // Staggered mode adds three prescaler bits, so a tick lands on step 7
  always_comb
  begin
    pre_mask = ~({DTCC_PW{1'b1}} << 4'(q.tctl[DTCC_TCTL_PRE +: 3]));
    if (stag)
    begin
      pre_mask = ~({DTCC_PW{1'b1}} << 4'(4'(q.tctl[DTCC_TCTL_PRE +: 3]) + 4'(DTCC_STAG_SHIFT)));
    end
  end

  assign tick_pre = ((q.pre & pre_mask) == pre_mask);

  genvar t;
  generate
    for (t = 0; t < 2; t++)
    begin : g_tmr
      logic [7:0] ctl;
      logic       src_tick;
      assign ctl = q.tctl[t*DTCC_TCTL_STRIDE +: DTCC_TCTL_STRIDE];
      always_comb
      begin
        unique case (ctl[DTCC_TCTL_SRC +: 2])
          DTCC_SRC_PRESC: src_tick = tick_pre;
          DTCC_SRC_AUX:   src_tick = aux_ovf_in;
          DTCC_SRC_EXT:   src_tick = (t == 0) ? ext_edge : 1'b0;
          default:        src_tick = 1'b0;
        endcase
      end
      assign tick[t]   = ctl[DTCC_TCTL_RUN] & src_tick;
      assign tmr_wr[t] = reg_wr_in && (reg_addr_in == DTCC_ADDR_TMR0 + 6'(t));
      assign inc[t]    = tick[t] & ~tmr_wr[t];
      always_comb
      begin
        if (tmr_wr[t])
          tmr_nx[t] = reg_wdata_in;
        else if (inc[t] && q.tmr[t] == DTCC_TMR_MAX)
          tmr_nx[t] = q.rel[t];
        else if (inc[t])
          tmr_nx[t] = q.tmr[t] + 16'h0001;
        else
          tmr_nx[t] = q.tmr[t];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < DTCC_NCH; c++)
    begin : g_ch
      logic [1:0] op;
      logic       tsel;
      logic [1:0] edg;
      logic [1:0] act;
      logic       rise;
      logic       fall;
      logic       own_req;
      logic       own_val;
      assign op   = q.mode[c][DTCC_MODE_OP +: 2];
      assign tsel = q.mode[c][DTCC_MODE_TSEL];
      assign edg  = q.mode[c][DTCC_MODE_EDGE +: 2];
      assign act  = q.mode[c][DTCC_MODE_ACT +: 2];
      assign rise = cc_pin_in[c] & ~q.pin_prev[c];
      assign fall = ~cc_pin_in[c] & q.pin_prev[c];
      assign is_cmp[c] = (op == DTCC_OP_CMP);
      assign cap_ev[c] = (op == DTCC_OP_CAP) && ((edg[0] & rise) | (edg[1] & fall));
      // Match is taken only on a real increment, never on a software load
      assign match[c]  = is_cmp[c] && inc[tsel] && (tmr_nx[tsel] == q.ccv[c]);
      assign own_req   = match[c] && (act != 2'h0);
      assign own_val   = (act == DTCC_ACT_SET) ? 1'b1 :
                         (act == DTCC_ACT_CLR) ? 1'b0 : ~q.outr[c];
      if (c < DTCC_STAG_STEPS)
      begin : g_lo
        logic dbl;
        assign dbl = q.octl[DTCC_OCTL_DBL + c];
        // Pair: low channel sets, high channel clears; set wins a tie
        assign out_req[c] = dbl ? (match[c] | match[c+DTCC_STAG_STEPS]) : own_req;
        assign out_val[c] = dbl ? match[c] : own_val;
      end
      else
      begin : g_hi
        assign out_req[c] = q.octl[DTCC_OCTL_DBL + c - DTCC_STAG_STEPS] ? 1'b0 : own_req;
        assign out_val[c] = own_val;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_q          = q;
    next_q.tmr      = tmr_nx;
    next_q.ovf      = {inc[1] && q.tmr[1] == DTCC_TMR_MAX, inc[0] && q.tmr[0] == DTCC_TMR_MAX};
    next_q.pre      = q.pre + 11'h001;
    next_q.pin_prev = cc_pin_in;
    next_q.ext_prev = ext_count_in;
    next_q.irq      = match | cap_ev;
    next_q.rdata    = DTCC_RST_WORD;
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        DTCC_ADDR_REL0:   next_q.rel[0] = reg_wdata_in;
        DTCC_ADDR_REL1:   next_q.rel[1] = reg_wdata_in;
        DTCC_ADDR_TCTL:   next_q.tctl   = reg_wdata_in;
        DTCC_ADDR_OUT:    next_q.outr   = reg_wdata_in;
        DTCC_ADDR_PEN:    next_q.pen    = reg_wdata_in;
        DTCC_ADDR_OCTL:   next_q.octl   = reg_wdata_in;
        DTCC_ADDR_SWTRIG: next_q.irq    = match | cap_ev | reg_wdata_in;
        default:
        begin
          if (reg_addr_in[5:4] == DTCC_ADDR_CCV[5:4])
            next_q.ccv[reg_addr_in[3:0]] = reg_wdata_in;
          else if (reg_addr_in[5:4] == DTCC_ADDR_MODE[5:4])
            next_q.mode[reg_addr_in[3:0]] = reg_wdata_in[7:0];
        end
      endcase
    end
    // Capture lands after the software write so a coincident event is kept
    for (int i = 0; i < DTCC_NCH; i++)
    begin
      if (cap_ev[i])
        next_q.ccv[i] = q.tmr[q.mode[i][DTCC_MODE_TSEL]];
      if (out_req[i])
      begin
        next_q.pend[i]     = 1'b1;
        next_q.pend_val[i] = out_val[i];
      end
      // Staggered: output i switches only on step i mod 8
      if (next_q.pend[i] && (!stag || 3'(i) == q.pre[2:0]))
      begin
        next_q.outr[i] = next_q.pend_val[i];
        next_q.pend[i] = 1'b0;
      end
    end
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        DTCC_ADDR_TMR0:   next_q.rdata = q.tmr[0];
        DTCC_ADDR_TMR1:   next_q.rdata = q.tmr[1];
        DTCC_ADDR_REL0:   next_q.rdata = q.rel[0];
        DTCC_ADDR_REL1:   next_q.rdata = q.rel[1];
        DTCC_ADDR_TCTL:   next_q.rdata = q.tctl;
        DTCC_ADDR_OUT:    next_q.rdata = q.outr;
        DTCC_ADDR_PEN:    next_q.rdata = q.pen;
        DTCC_ADDR_OCTL:   next_q.rdata = q.octl;
        default:
        begin
          if (reg_addr_in[5:4] == DTCC_ADDR_CCV[5:4])
            next_q.rdata = q.ccv[reg_addr_in[3:0]];
          else if (reg_addr_in[5:4] == DTCC_ADDR_MODE[5:4])
            next_q.rdata = {8'h00, q.mode[reg_addr_in[3:0]]};
          else
            next_q.rdata = DTCC_RST_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      q <= '0;
    else
      q <= next_q;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata_out   = q.rdata;
  assign irq_out         = q.irq;
  assign out_reg_out     = q.outr;
  assign cc_pin_out      = q.outr;
  // Pin driven only when routed and the channel compares; else it is an input
  assign cc_pin_oe_n_out = ~(q.pen & is_cmp);
  assign timer_ovf_out   = q.ovf;

endmodule
`default_nettype wire

//--- bench/dtcc_unit_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dtcc_unit_monitor
  import dtcc_pkg::*;
(
  // Clock and reset
  input wire logic                clk_in,
  input wire logic                arst_n_in,
  // Register port
  input wire logic [DTCC_AW-1:0]  reg_addr_in,
  input wire logic [DTCC_DW-1:0]  reg_wdata_in,
  input wire logic                reg_wr_in,
  input wire logic                reg_rd_in,
  input wire logic [DTCC_DW-1:0]  reg_rdata_out,
  // Count sources
  input wire logic                aux_ovf_in,
  input wire logic                ext_count_in,
  // Pins and events
  input wire logic [DTCC_NCH-1:0] cc_pin_in,
  input wire logic [DTCC_NCH-1:0] cc_pin_out,
  input wire logic [DTCC_NCH-1:0] cc_pin_oe_n_out,
  input wire logic [DTCC_NCH-1:0] irq_out,
  input wire logic [DTCC_NCH-1:0] out_reg_out,
  input wire logic [1:0]          timer_ovf_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data not idle");
  a_reset_pins: assert property ($past(!arst_n_in) |-> cc_pin_oe_n_out == 16'hFFFF
    && irq_out == 16'h0000) else $error("pins driven after reset");
  a_pin_mirror: assert property (cc_pin_out == out_reg_out)
    else $error("pin output differs from output register");
  // A staggered switch may land up to seven clocks after its match pulse
  a_out_cause: assert property ($changed(out_reg_out) |->
    $past(reg_wr_in && reg_addr_in == DTCC_ADDR_OUT) || irq_out != 16'h0000 ||
    $past(irq_out, 1) != 16'h0000 || $past(irq_out, 2) != 16'h0000 ||
    $past(irq_out, 3) != 16'h0000 || $past(irq_out, 4) != 16'h0000 ||
    $past(irq_out, 5) != 16'h0000 || $past(irq_out, 6) != 16'h0000 ||
    $past(irq_out, 7) != 16'h0000) else $error("output register changed without cause");
  a_sw_irq: assert property (reg_wr_in && reg_addr_in == DTCC_ADDR_SWTRIG |=>
    (irq_out & $past(reg_wdata_in)) == $past(reg_wdata_in)) else $error("soft irq missing");
  a_swtrig_zero: assert property (reg_rd_in && reg_addr_in == DTCC_ADDR_SWTRIG |=>
    reg_rdata_out == 16'h0000) else $error("trigger register reads nonzero");
  a_reload_back: assert property (reg_wr_in && reg_addr_in[5:1] == 5'h01 ##2
    reg_rd_in && reg_addr_in == $past(reg_addr_in, 2) |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("reload readback wrong");
  a_mode_byte: assert property (reg_wr_in && reg_addr_in[5:4] == 2'h2 ##2
    reg_rd_in && reg_addr_in == $past(reg_addr_in, 2) |=>
    reg_rdata_out == ($past(reg_wdata_in, 3) & 16'h00FF)) else $error("mode readback wrong");
  a_out_read: assert property (reg_rd_in && reg_addr_in == DTCC_ADDR_OUT |=>
    reg_rdata_out == $past(out_reg_out)) else $error("output register readback wrong");
endmodule
bind dtcc_unit dtcc_unit_monitor dtcc_unit_monitor_i (.clk_in, .arst_n_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .aux_ovf_in, .ext_count_in,
  .cc_pin_in, .cc_pin_out, .cc_pin_oe_n_out, .irq_out, .out_reg_out, .timer_ovf_out);
`default_nettype wire

//--- bench/dtcc_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module dtcc_pin_model
(
  // Far side drive and unit drive
  input  wire logic [15:0] drive_in,
  input  wire logic [15:0] oe_n_in,
  input  wire logic [15:0] pin_out_in,
  // Resolved pin level
  output logic      [15:0] level_out
);
  // One wire per channel: the unit wins where it drives, else the far side
  assign level_out = (~oe_n_in & pin_out_in) | (oe_n_in & drive_in);
endmodule
`default_nettype wire

//--- bench/dual_timer_capture_compare_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dual_timer_capture_compare_unit_tb
  import dtcc_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [5:0]  addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] pin_cmd = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        aux = 1'b0;
  logic        ext = 1'b0;
  logic [15:0] rdata, pin_out, oe_n, irq, outr, pin_lvl, v0, v1;
  logic [1:0]  ovf;
  int          mismatches = 0;
  int          compares = 0;
  int          ovf_cnt = 0;

  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) if (ovf[0] === 1'b1) ovf_cnt++;

  dtcc_unit dtcc_unit_i (.clk_in, .arst_n_in, .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .aux_ovf_in(aux),
    .ext_count_in(ext), .cc_pin_in(pin_lvl), .cc_pin_out(pin_out),
    .cc_pin_oe_n_out(oe_n), .irq_out(irq), .out_reg_out(outr), .timer_ovf_out(ovf));
  dtcc_pin_model dtcc_pin_model_i (.drive_in(pin_cmd), .oe_n_in(oe_n),
    .pin_out_in(pin_out), .level_out(pin_lvl));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [5:0] a, output logic [15:0] v);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chkr(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] v;
    rreg(a, v);
    chk(v, e);
  endtask
  task automatic pulse(input int s);
    @(posedge clk_in);
    aux <= (s == 1);
    ext <= (s == 2);
    @(posedge clk_in);
    aux <= 1'b0;
    ext <= 1'b0;
  endtask
  task automatic wait_irq(input int b);
    int n;
    n = 0;
    while (irq[b] !== 1'b1 && n < 40)
    begin
      @(posedge clk_in);
      #1 n++;
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    chkr(DTCC_ADDR_OUT, 16'h0000);
    chkr(6'h3F, 16'h0000);
    chk(oe_n, 16'hFFFF);
    wreg(DTCC_ADDR_REL0, 16'h1234);
    chkr(DTCC_ADDR_REL0, 16'h1234);
    wreg(DTCC_ADDR_REL1, 16'hABCD);
    chkr(DTCC_ADDR_REL1, 16'hABCD);
    wreg(DTCC_ADDR_MODE + 6'h0F, 16'hA55A);
    chkr(DTCC_ADDR_MODE + 6'h0F, 16'h005A);
    wreg(DTCC_ADDR_MODE + 6'h0F, 16'h0000);
    // Write beats the tick, then wrap loads the reload value
    wreg(DTCC_ADDR_TCTL, 16'h0040);
    wreg(DTCC_ADDR_TMR0, 16'hFFFE);
    chkr(DTCC_ADDR_TMR0, 16'hFFFF);
    chkr(DTCC_ADDR_TMR0, 16'h1235);
    wreg(DTCC_ADDR_TCTL, 16'h0000);
    chk(16'(ovf_cnt), 16'h0001);
    // Samples 8 clocks apart: 8 ticks plain, 1 tick staggered
    for (int s = 0; s < 2; s++)
    begin
      wreg(DTCC_ADDR_OCTL, 16'(s));
      wreg(DTCC_ADDR_TCTL, 16'h0040);
      rreg(DTCC_ADDR_TMR0, v0);
      repeat (6) @(posedge clk_in);
      rreg(DTCC_ADDR_TMR0, v1);
      chk(v1 - v0, s ? 16'h0001 : 16'h0008);
      wreg(DTCC_ADDR_TCTL, 16'h0000);
    end
    wreg(DTCC_ADDR_OCTL, 16'h0000);
    for (int s = 1; s < 3; s++)
    begin
      wreg(DTCC_ADDR_TMR0, 16'h0000);
      wreg(DTCC_ADDR_TCTL, 16'h0040 | 16'(s << 3));
      repeat (3) pulse(s);
      repeat (4) @(posedge clk_in);
      wreg(DTCC_ADDR_TCTL, 16'h0000);
      chkr(DTCC_ADDR_TMR0, 16'h0003);
    end
    wreg(DTCC_ADDR_TMR1, 16'h4321);
    wreg(DTCC_ADDR_MODE + 6'h03, 16'h000D);
    @(posedge clk_in);
    pin_cmd <= 16'h0008;
    wait_irq(3);
    chk(irq, 16'h0008);
    chkr(DTCC_ADDR_CCV + 6'h03, 16'h4321);
    // Set, clear and toggle all on one match
    wreg(DTCC_ADDR_OUT, 16'h0040);
    for (int c = 5; c < 8; c++)
    begin
      wreg(DTCC_ADDR_CCV + 6'(c), 16'h0010);
      wreg(DTCC_ADDR_MODE + 6'(c), 16'h0002 | 16'((c - 4) << 5));
    end
    wreg(DTCC_ADDR_PEN, 16'h0020);
    wreg(DTCC_ADDR_TMR0, 16'h000C);
    wreg(DTCC_ADDR_TCTL, 16'h0040);
    wait_irq(5);
    chk(irq, 16'h00E0);
    chk(outr, 16'h00A0);
    chk(pin_lvl & ~oe_n, 16'h0020);
    wreg(DTCC_ADDR_TCTL, 16'h0000);
    wreg(DTCC_ADDR_SWTRIG, 16'hA5C3);
    #1 chk(irq, 16'hA5C3);
    chkr(DTCC_ADDR_SWTRIG, 16'h0000);
    // Pair 1, staggered: channel 1 sets and channel 9 clears output 1 on step 1
    wreg(DTCC_ADDR_OCTL, 16'h0201);
    wreg(DTCC_ADDR_CCV + 6'h01, 16'h4325);
    wreg(DTCC_ADDR_CCV + 6'h09, 16'h4327);
    wreg(DTCC_ADDR_MODE + 6'h01, 16'h0006);
    wreg(DTCC_ADDR_MODE + 6'h09, 16'h0026);
    wreg(DTCC_ADDR_TCTL, 16'h4000);
    for (int k = 0; k < 2; k++)
    begin
      wait_irq(k ? 9 : 1);
      chk(irq, k ? 16'h0200 : 16'h0002);
      @(posedge clk_in);
      #1 chk(outr, k ? 16'h00A2 : 16'h00A0);
      @(posedge clk_in);
      #1 chk(outr, k ? 16'h00A0 : 16'h00A2);
    end
    // Falling edge capture on the second timer
    wreg(DTCC_ADDR_TCTL, 16'h0000);
    wreg(DTCC_ADDR_TMR1, 16'h1357);
    wreg(DTCC_ADDR_MODE + 6'h03, 16'h0015);
    @(posedge clk_in);
    pin_cmd <= 16'h0000;
    wait_irq(3);
    chk(irq, 16'h0008);
    chkr(DTCC_ADDR_CCV + 6'h03, 16'h1357);
    conclude();
  end

  initial
  begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
